// [design/pps_sequencer.sv]
// power-up, normal park and fast park sequencer of the display controller
// assumes pins arrive asynchronously and are synchronised here; one 10 MHz clock
`default_nettype none
module pps_sequencer
  import pps_pkg::*;
#(
  parameter int BOOT_CYC = BOOT_CYCLES,
  parameter int SETUP_CYC = SETUP_CYCLES,
  parameter int PARK_CYC = PARK_CYCLES
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic active_low_reset_in,
  input wire logic fast_park_request_n_in,
  input wire logic projector_power_request_in,
  input wire logic companion_ready_in,
  input wire logic core_power_good_in,
  output logic init_busy_out,
  output logic init_busy_oe_out,
  output logic bus_ready_out,
  output logic display_active_out,
  output logic mirror_park_out,
  output logic fast_park_active_out,
  output logic mirrors_parked_out,
  output logic companion_reset_n_out,
  output logic companion_setup_out,
  output logic io_drive_enable_out
);
  // ******************************************************
  // pin synchronisation
  // ******************************************************
  pps_sync_if pins_if ();

  pps_pin_sync u_sync (
    .clock_in (clock_in),
    .resetn_in (resetn_in),
    .raw_in ({core_power_good_in, companion_ready_in, projector_power_request_in,
              fast_park_request_n_in, active_low_reset_in}),
    .lvl_if (pins_if.drv)
  );

  logic rst_hi;
  logic park_hi;
  logic proj_hi;
  logic comp_rdy;
  logic pwr_ok;
  assign rst_hi = pins_if.level[PIN_RST];
  assign park_hi = pins_if.level[PIN_PARK];
  assign proj_hi = pins_if.level[PIN_PROJ];
  assign comp_rdy = pins_if.level[PIN_CRDY];
  assign pwr_ok = pins_if.level[PIN_PWR];

  localparam logic [CNT_W-1:0] BOOT_LAST = CNT_W'(BOOT_CYC - 1);
  localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] PARK_LAST = CNT_W'(PARK_CYC - 1);
  localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(FAST_PARK_CYCLES - 1);
  // small slack over the fixed fast park length for the output pipeline
  localparam int FP_MAX = FAST_PARK_CYCLES + 2;

  pps_state_e state_r;
  pps_state_e state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic active_st;

  // ******************************************************
  // sequencing
  // ******************************************************
  // states in which the mirrors may be driven and a fault must park them
  assign active_st = (state_r == ST_BOOT) || (state_r == ST_WAIT_COMP) || (state_r == ST_SETUP) ||
                     (state_r == ST_READY) || (state_r == ST_PARK);

  always_comb begin
    state_nxt = state_r;
    if (!rst_hi) begin
      state_nxt = ST_RESET;
    end else if (active_st && !park_hi) begin
      state_nxt = ST_FAST_PARK;
    end else begin
      case (state_r)
        ST_RESET: begin
          // a low park request at release would block initialization
          state_nxt = park_hi ? ST_BOOT : ST_HOLD;
        end
        ST_HOLD: begin
          if (park_hi) begin
            state_nxt = ST_BOOT;
          end
        end
        ST_BOOT: begin
          if (cnt_r == BOOT_LAST) begin
            state_nxt = ST_WAIT_COMP;
          end
        end
        ST_WAIT_COMP: begin
          if (comp_rdy) begin
            state_nxt = ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_r == SETUP_LAST) begin
            state_nxt = ST_READY;
          end
        end
        ST_READY: begin
          if (!proj_hi) begin
            state_nxt = ST_PARK;
          end
        end
        ST_PARK: begin
          if (cnt_r == PARK_LAST) begin
            state_nxt = ST_PARKED;
          end
        end
        ST_FAST_PARK: begin
          if (cnt_r == FAST_LAST) begin
            state_nxt = ST_PARKED;
          end
        end
        ST_PARKED: begin
          state_nxt = ST_PARKED;
        end
        default: begin
          state_nxt = ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one timer, restarted on every state change
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // ******************************************************
  // registered outputs
  // ******************************************************
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      init_busy_out <= 1'h0;
      init_busy_oe_out <= 1'h0;
      io_drive_enable_out <= 1'h0;
    end else begin
      init_busy_out <= (state_r == ST_HOLD) || (state_r == ST_BOOT) ||
                       (state_r == ST_WAIT_COMP) || (state_r == ST_SETUP);
      // undriven in reset or without core power; the board pull-up wins
      init_busy_oe_out <= (state_r != ST_RESET) && pwr_ok;
      io_drive_enable_out <= (state_r != ST_RESET) && pwr_ok;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      bus_ready_out <= 1'h0;
      display_active_out <= 1'h0;
      companion_reset_n_out <= 1'h0;
      companion_setup_out <= 1'h0;
    end else begin
      bus_ready_out <= (state_r == ST_READY);
      display_active_out <= (state_r == ST_READY) && proj_hi;
      companion_reset_n_out <= (state_r != ST_RESET) && (state_r != ST_HOLD);
      companion_setup_out <= (state_r == ST_SETUP);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      mirror_park_out <= 1'h0;
      fast_park_active_out <= 1'h0;
      mirrors_parked_out <= 1'h0;
    end else begin
      mirror_park_out <= (state_r == ST_PARK);
      fast_park_active_out <= (state_r == ST_FAST_PARK);
      mirrors_parked_out <= (state_r == ST_PARKED);
    end
  end

  // ******************************************************
  // checks
  // ******************************************************
  logic [CNT_W-1:0] park_run_r;
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      park_run_r <= '0;
    end else if (mirror_park_out) begin
      park_run_r <= park_run_r + CNT_W'(1);
    end else begin
      park_run_r <= '0;
    end
  end

  a_busy_after_release: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (state_r == ST_RESET && rst_hi && park_hi && pwr_ok) ##1 pwr_ok |=> init_busy_out && init_busy_oe_out)
    else $error("busy flag not driven high after reset release");

  a_reset_tristates_io: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    !rst_hi |=> ##1 (!init_busy_oe_out && !io_drive_enable_out && !bus_ready_out))
    else $error("outputs still driven while reset held");

  a_core_loss_hiz: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    !pwr_ok |=> (!init_busy_oe_out && !io_drive_enable_out))
    else $error("io outputs driven without core power");

  a_boot_ends: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (state_r == ST_BOOT && cnt_r == BOOT_LAST && rst_hi && park_hi) |=> state_r == ST_WAIT_COMP)
    else $error("boot did not end at its length");

  a_ready_after_setup: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    $rose(bus_ready_out) |-> $past(companion_setup_out) && !init_busy_out)
    else $error("bus ready without companion setup");

  a_request_low_parks: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (state_r == ST_READY && !proj_hi && rst_hi && park_hi) ##1 (rst_hi && park_hi)
    |=> mirror_park_out && !display_active_out)
    else $error("falling request did not start park");

  a_park_bounded: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    park_run_r <= CNT_W'(PARK_CYC))
    else $error("normal park longer than allowed");

  a_fast_overrides: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (state_r == ST_PARK && !park_hi && rst_hi) |=> state_r == ST_FAST_PARK)
    else $error("fast park did not override normal park");

  a_fast_finishes: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    $rose(fast_park_active_out) |-> ##[1:FP_MAX] (mirrors_parked_out || !rst_hi))
    else $error("fast park not finished in time");

  a_parked_order: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    $rose(mirrors_parked_out) |-> $past(mirror_park_out || fast_park_active_out))
    else $error("parked without a park phase");

  a_display_on_request: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (state_r == ST_READY && proj_hi) |=> display_active_out)
    else $error("display not active while request high");

  a_busy_low_done: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (state_r == ST_SETUP && cnt_r == SETUP_LAST && rst_hi && park_hi)
    |=> ##1 (!init_busy_out && bus_ready_out))
    else $error("busy flag not low when setup done");

  a_hold_no_boot: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (state_r == ST_HOLD && !park_hi) |=> (state_r == ST_HOLD || state_r == ST_RESET))
    else $error("boot started with park request low");

  a_wait_companion: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (state_r == ST_WAIT_COMP && !comp_rdy && rst_hi && park_hi) |=> state_r == ST_WAIT_COMP)
    else $error("setup started before companion ready");

  a_fast_ends: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (state_r == ST_FAST_PARK && cnt_r == FAST_LAST && rst_hi) |=> state_r == ST_PARKED)
    else $error("fast park did not end at its length");

  a_parked_stays: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (state_r == ST_PARKED && rst_hi) |=> state_r == ST_PARKED)
    else $error("parked state left without reset");
endmodule
`default_nettype wire

// [common/pps_pkg.sv]
// constants of the projector power sequencer: pin slots, states, timing
// assumes a 10 MHz core clock; times are kept in their own units
`default_nettype none
package pps_pkg;
  // ******************************************************
  // clock and times
  // ******************************************************
  localparam int CLK_MHZ = 10;
  localparam int BOOT_TIME_MS = 100;
  localparam int SETUP_TIME_US = 2750;
  localparam int PARK_TIME_MS = 20;
  localparam int FAST_PARK_TIME_US = 32;
  localparam int BOOT_CYCLES = BOOT_TIME_MS * 1000 * CLK_MHZ;
  localparam int SETUP_CYCLES = SETUP_TIME_US * CLK_MHZ;
  localparam int PARK_CYCLES = PARK_TIME_MS * 1000 * CLK_MHZ;
  localparam int FAST_PARK_CYCLES = FAST_PARK_TIME_US * CLK_MHZ;
  localparam int CNT_W = 20;

  // ******************************************************
  // synchronised pin slots
  // ******************************************************
  localparam int PIN_W = 5;
  localparam int PIN_RST = 0;
  localparam int PIN_PARK = 1;
  localparam int PIN_PROJ = 2;
  localparam int PIN_CRDY = 3;
  localparam int PIN_PWR = 4;
  localparam logic [PIN_W-1:0] PIN_INIT = 5'h02;

  // ******************************************************
  // sequencer states
  // ******************************************************
  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_HOLD = 4'h1,
    ST_BOOT = 4'h2,
    ST_WAIT_COMP = 4'h3,
    ST_SETUP = 4'h4,
    ST_READY = 4'h5,
    ST_PARK = 4'h6,
    ST_FAST_PARK = 4'h7,
    ST_PARKED = 4'h8
  } pps_state_e;
endpackage
`default_nettype wire

// [common/pps_sync_if.sv]
// carries the synchronised pin levels from the synchroniser to the sequencer
// assumes both ends run on the same core clock
`default_nettype none
interface pps_sync_if;
  import pps_pkg::*;
  logic [PIN_W-1:0] level;
  modport drv (output level);
  modport use_side (input level);
endinterface
`default_nettype wire

// [design/pps_pin_sync.sv]
// three-stage synchroniser for the asynchronous control pins
// a bit changes once the second and third stages agree
`default_nettype none
module pps_pin_sync
  import pps_pkg::*;
(
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [PIN_W-1:0] raw_in,
  pps_sync_if.drv lvl_if
);
  logic [PIN_W-1:0] s1_r;
  logic [PIN_W-1:0] s2_r;
  logic [PIN_W-1:0] s3_r;
  logic [PIN_W-1:0] lvl_r;
  logic [PIN_W-1:0] lvl_nxt;

  // first stage feeds only the second
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      s1_r <= PIN_INIT;
      s2_r <= PIN_INIT;
      s3_r <= PIN_INIT;
    end else begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // disagreement keeps the old level
  assign lvl_nxt = (s2_r & ~(s2_r ^ s3_r)) | (lvl_r & (s2_r ^ s3_r));

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      lvl_r <= PIN_INIT;
    end else begin
      lvl_r <= lvl_nxt;
    end
  end

  assign lvl_if.level = lvl_r;
endmodule
`default_nettype wire

// [dv/pps_companion_model.sv]
// model of the companion logic that faces the sequencer
// assumes it shares the core clock and sees the companion reset output
`default_nettype none
module pps_companion_model #(
  parameter int BOOT_DLY = 10
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  output logic ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_r;
  // ready only after its own boot, dropped at once while held in reset
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      cnt_r <= 0;
      ready_out <= 1'h0;
    end else if (cnt_r < BOOT_DLY) begin
      cnt_r <= cnt_r + 1;
    end else begin
      ready_out <= 1'h1;
    end
  end
endmodule
`default_nettype wire

// [dv/projector_power_sequencer_tb.sv]
// self-checking bench of the projector power sequencer
// assumes shortened boot, setup and park counts and a companion model
`default_nettype none
module projector_power_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pps_pkg::*;
  localparam int BOOT_C = 50;
  localparam int SETUP_C = 20;
  localparam int PARK_C = 30;
  typedef struct {
    logic [3:0] pins;
    int dly;
    logic [9:0] mask;
    logic [9:0] exp;
  } pps_row_s;
  logic clock_in, resetn_in, rst_pin, park_n, proj, cready, pgood;
  logic busy, busy_oe, bus_rdy, disp, mpark, fpark, parked, crst_n, csetup, io_en;
  logic [9:0] outs;
  logic busy_pin;
  int n_fail = 0;
  int cmp_count = 0;
  int n;
  pps_row_s rows[6];
  assign outs = {busy, busy_oe, bus_rdy, disp, mpark, fpark, parked, crst_n, csetup, io_en};
  // busy flag pin as the board sees it: the pull-up wins when undriven
  assign busy_pin = busy_oe ? busy : 1'h1;

  pps_sequencer #(.BOOT_CYC(BOOT_C), .SETUP_CYC(SETUP_C), .PARK_CYC(PARK_C)) u_pps_sequencer (
    .clock_in(clock_in), .resetn_in(resetn_in), .active_low_reset_in(rst_pin),
    .fast_park_request_n_in(park_n), .projector_power_request_in(proj),
    .companion_ready_in(cready), .core_power_good_in(pgood),
    .init_busy_out(busy), .init_busy_oe_out(busy_oe), .bus_ready_out(bus_rdy),
    .display_active_out(disp), .mirror_park_out(mpark), .fast_park_active_out(fpark),
    .mirrors_parked_out(parked), .companion_reset_n_out(crst_n),
    .companion_setup_out(csetup), .io_drive_enable_out(io_en));

  // companion boot outlasts the controller boot so that the wait state is used
  pps_companion_model #(.BOOT_DLY(70)) u_pps_companion_model (
    .clock_in(clock_in), .reset_n_in(crst_n), .ready_out(cready));

  // ******************************************************
  // helpers
  // ******************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // counts whole cycles until the output bit takes the value
  task automatic wait_bit(input int idx, input logic val, input int bound);
    n = 0;
    while (outs[idx] !== val) begin
      if (n == bound) begin
        check("wait timeout", 0, 1);
        print_verdict();
      end
      @(negedge clock_in);
      n++;
    end
  endtask

  // pin reset pulse; park request already high before release
  task automatic boot_up();
    rst_pin = 0;
    repeat (10) @(negedge clock_in);
    rst_pin = 1;
    wait_bit(7, 1, 300);
  endtask

  // reference clock runs from time zero, well before any release
  initial begin
    clock_in = 0;
    forever #50 clock_in = ~clock_in;
  end

  // ******************************************************
  // main sequence
  // ******************************************************
  initial begin
    rows = '{
      '{4'h7, 10, 10'h1F9, 10'h000},
      '{4'hF, 8, 10'h3FF, 10'h305},
      '{4'hF, 120, 10'h3FF, 10'h1C5},
      '{4'hD, 10, 10'h078, 10'h020},
      '{4'hD, 40, 10'h078, 10'h008},
      '{4'h5, 10, 10'h1F9, 10'h000}};
    resetn_in = 0;
    rst_pin = 0;
    park_n = 1;
    proj = 1;
    pgood = 1;
    repeat (4) @(negedge clock_in);
    resetn_in = 1;
    foreach (rows[i]) begin
      {rst_pin, park_n, proj, pgood} = rows[i].pins;
      repeat (rows[i].dly) @(negedge clock_in);
      check("row outputs", outs & rows[i].mask, rows[i].exp);
    end
    check("busy pin pulled up", busy_pin, 1);
    // release with park request still low: busy driven, no boot
    park_n = 0;
    rst_pin = 1;
    repeat (100) @(negedge clock_in);
    check("hold", {busy, busy_oe, bus_rdy}, 3'h6);
    park_n = 1;
    wait_bit(1, 1, 300);
    check("boot length", n >= BOOT_C, 1);
    wait_bit(7, 1, 100);
    check("setup length", n, SETUP_C);
    check("busy at ready", busy, 0);
    // request back high mid-park has to be ignored
    proj = 0;
    wait_bit(5, 1, 20);
    proj = 1;
    wait_bit(5, 0, PARK_C + 10);
    check("park length", n >= PARK_C - 1 && n <= PARK_C + 1, 1);
    check("parked", {parked, disp}, 2'h2);
    boot_up();
    proj = 0;
    wait_bit(5, 1, 20);
    repeat (5) @(negedge clock_in);
    park_n = 0;
    wait_bit(4, 1, 20);
    check("fast over normal", mpark, 0);
    wait_bit(4, 0, FAST_PARK_CYCLES + 10);
    check("fast length", n >= FAST_PARK_CYCLES - 1 && n <= FAST_PARK_CYCLES + 1, 1);
    check("fast parked", parked, 1);
    park_n = 1;
    proj = 1;
    boot_up();
    pgood = 0;
    repeat (8) @(negedge clock_in);
    check("power lost", {busy_oe, io_en}, 2'h0);
    pgood = 1;
    boot_up();
    resetn_in = 0;
    repeat (2) @(negedge clock_in);
    check("logic reset", outs, 10'h000);
    print_verdict();
  end
endmodule
`default_nettype wire
